// ===== dspwm_pkg.sv
// Purpose: shared constants and types of the dual-slope pwm timer block
// Assumes: 8-bit register port, one clock, prescaled tick given as an enable
// Notes: offsets are byte addresses on the plain register port
package dspwm_pkg;

    // data width of counter, compare values and registers
    localparam int unsigned DATA_W = 8;

    // register offsets
    localparam logic [7:0] OFS_CTRL_A = 8'h44;
    localparam logic [7:0] OFS_CTRL_B = 8'h45;
    localparam logic [7:0] OFS_COUNT = 8'h46;
    localparam logic [7:0] OFS_CMP_A = 8'h47;
    localparam logic [7:0] OFS_CMP_B = 8'h48;
    localparam logic [7:0] OFS_FLAGS = 8'h49;
    localparam logic [7:0] OFS_PIN_DIR = 8'h4A;

    // control a fields: output_action_a [7:6], output_action_b [5:4], waveform_select_lo [1:0]
    localparam int unsigned ACT_A_POS = 6;
    localparam int unsigned ACT_B_POS = 4;
    localparam int unsigned WAVE_LO_POS = 0;
    localparam logic [7:0] CTRL_A_WMASK = 8'hF3;
    // control b field: waveform_select_hi
    localparam int unsigned WAVE_HI_POS = 3;
    // flags fields, write one to clear
    localparam int unsigned FLAG_OVF_POS = 0;
    localparam int unsigned FLAG_MATCH_POS = 1;
    // pin direction fields, one bit per channel from bit 0
    localparam int unsigned DIR_POS = 0;

    // reset values
    localparam logic [7:0] CTRL_A_RST = 8'h00;
    localparam logic WAVE_HI_RST = 1'b0;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] CMP_RST = 8'h00;
    localparam logic [2:0] FLAGS_RST = 3'h0;
    localparam logic [1:0] PIN_DIR_RST = 2'h0;

    // counter limits
    localparam logic [7:0] BOTTOM = 8'h00;
    localparam logic [7:0] MAX = 8'hFF;
    // dual-slope period in ticks at top max
    localparam int unsigned DUAL_PERIOD_TICKS = 510;

    // waveform_select codes
    localparam logic [2:0] WAVE_NORMAL = 3'h0;
    localparam logic [2:0] WAVE_DUAL_MAX = 3'h1;
    localparam logic [2:0] WAVE_CTC = 3'h2;
    localparam logic [2:0] WAVE_FAST_MAX = 3'h3;
    localparam logic [2:0] WAVE_DUAL_CMP = 3'h5;
    localparam logic [2:0] WAVE_FAST_CMP = 3'h7;

    // output_action codes
    localparam logic [1:0] ACT_OFF = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;

    // counting family of the selected waveform
    typedef enum logic [1:0] {
        DSPWM_NON_PWM,
        DSPWM_FAST,
        DSPWM_DUAL
    } dspwm_class_e;

endpackage

// ===== dspwm_wave_unit.sv
// Purpose: one output compare channel: waveform level and pin override
// Assumes: match, top and bottom events come from the counter, valid with tick
// Notes: toggle in pwm modes exists only where CAN_TOGGLE is set
`timescale 1ns/10ps
module dspwm_wave_unit #(
    parameter bit CAN_TOGGLE = 1'b1
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic resetn_in,
    // counter events
    input wire logic tick_in,
    input wire logic match_in,
    input wire logic cmp_is_top_in,
    input wire logic at_top_in,
    input wire logic at_bottom_in,
    input wire logic counting_up_in,
    // configuration
    input wire dspwm_pkg::dspwm_class_e class_in,
    input wire logic [1:0] action_in,
    input wire logic wave_hi_in,
    // pin
    input wire logic port_data_in,
    input wire logic pin_dir_in,
    output logic pin_out,
    output logic pin_oe_out,
    output logic wave_out
);

    logic wave;
    logic next_wave;

    // event decode
    wire pwm_mode = (class_in != dspwm_pkg::DSPWM_NON_PWM);
    wire act_hi = action_in[1];
    wire toggle_on = (action_in == dspwm_pkg::ACT_TOGGLE)
        && (!pwm_mode || (CAN_TOGGLE && wave_hi_in)); // RULE6 RULE14
    // compare at top, action high: match ignored
    wire suppress = pwm_mode && act_hi && cmp_is_top_in; // RULE16 RULE17
    wire hit = tick_in && match_in && !suppress; // RULE20
    wire connected = (action_in != dspwm_pkg::ACT_OFF)
        && !(pwm_mode && action_in == dspwm_pkg::ACT_TOGGLE && !toggle_on); // RULE7 RULE6

    // next level; only events move it, new action waits for a match, or in pwm modes a bottom or top event
    always_comb begin
        next_wave = wave; // RULE18
        unique case (class_in)
            dspwm_pkg::DSPWM_NON_PWM: begin
                if (hit) begin
                    unique case (action_in)
                        dspwm_pkg::ACT_TOGGLE: next_wave = ~wave; // RULE14
                        dspwm_pkg::ACT_CLEAR: next_wave = 1'b0; // RULE14
                        dspwm_pkg::ACT_SET: next_wave = 1'b1; // RULE14
                        dspwm_pkg::ACT_OFF: next_wave = wave; // RULE14
                    endcase
                end
            end
            dspwm_pkg::DSPWM_FAST: begin
                if (toggle_on && hit) begin
                    next_wave = ~wave; // RULE6
                end else if (act_hi) begin
                    if (tick_in && at_bottom_in) begin
                        next_wave = ~action_in[0]; // RULE15 RULE16
                    end
                    if (hit) begin
                        next_wave = action_in[0]; // RULE15
                    end
                end
            end
            dspwm_pkg::DSPWM_DUAL: begin
                if (toggle_on && hit) begin
                    next_wave = ~wave; // RULE6
                end else if (act_hi) begin
                    // forced edge at bottom keeps the period symmetric
                    if (tick_in && at_bottom_in) begin
                        next_wave = ~action_in[0]; // RULE10 RULE11
                    end
                    if (tick_in && at_top_in && cmp_is_top_in) begin
                        next_wave = ~action_in[0]; // RULE17 RULE9
                    end
                    // a match at bottom counts as up, so compare at bottom stays low
                    if (hit) begin
                        next_wave = counting_up_in ? action_in[0] : ~action_in[0]; // RULE5 RULE9
                    end
                end
            end
            default: next_wave = wave;
        endcase
    end

    // level register
    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            wave <= 1'b0;
        end else begin
            wave <= next_wave;
        end
    end

    // pin override: driver enabled only by the direction bit
    assign pin_out = connected ? wave : port_data_in; // RULE7
    assign pin_oe_out = pin_dir_in; // RULE8
    assign wave_out = wave;

endmodule

// ===== dspwm_timer.sv
// Purpose: 8-bit timer with dual-slope, single-slope and non-pwm waveforms
// Assumes: tick_enable_in is a one-cycle enable from an external prescaler
// Notes: registers sit on a plain port, read data stands one cycle later
// Behaviour
// RULE1: waveform modes 1 and 5 count up then down
// RULE2: mode 1 top is 0xFF, mode 5 uses compare a
// RULE3: count holds top one tick, then counts down
// RULE4: dual-slope sets overflow flag at bottom
// RULE5: action two clears up, sets down; three opposite
// RULE6: action one toggles a only with waveform high bit
// RULE7: nonzero action hands pin to waveform
// RULE8: pin driven only when direction bit is output
// RULE9: compare bottom low, compare max high, inverted opposite
// RULE10: leaving max still gives edge at bottom
// RULE11: missed up match still gives edge at bottom
// RULE12: dual-slope period is 510 ticks
// RULE13: counter advances only on tick enable
// RULE14: non-pwm actions: off, toggle, clear, set
// RULE15: single-slope: match level, opposite at bottom
// RULE16: single-slope compare at top: action at bottom
// RULE17: dual-slope compare at top: action at top
// RULE18: new action takes effect at next match; pwm modes also apply it at the next bottom or top event
// RULE19: waveform select joins control a and b bits
// RULE20: compare evaluated and output updated each tick
`timescale 1ns/10ps
module dspwm_timer #(
    parameter int unsigned CHANNELS = 2
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic resetn_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [7:0] reg_rdata_out,
    // prescaled timer tick
    input wire logic tick_enable_in,
    // normal port data for the waveform pins, channel a in bit 0
    input wire logic [CHANNELS-1:0] port_data_in,
    // waveform pins, channel a in bit 0
    output logic [CHANNELS-1:0] pin_out,
    output logic [CHANNELS-1:0] pin_oe_out,
    output logic [CHANNELS-1:0] wave_out,
    // status
    output logic [7:0] timer_count_out,
    output logic count_up_out,
    output logic overflow_flag_out,
    output logic [CHANNELS-1:0] match_flag_out
);

    // stored state
    logic [7:0] ctrl_a;
    logic wave_hi;
    logic [7:0] timer_count;
    logic count_up;
    logic [7:0] cmp_buf [CHANNELS];
    logic [7:0] cmp_act [CHANNELS];
    logic [CHANNELS:0] flags;
    logic [CHANNELS-1:0] pin_dir;
    logic [7:0] rdata;
    logic [7:0] next_count;
    logic next_up;

    // register write decode
    wire wr_ctrl_a = reg_write_in && (reg_addr_in == dspwm_pkg::OFS_CTRL_A);
    wire wr_ctrl_b = reg_write_in && (reg_addr_in == dspwm_pkg::OFS_CTRL_B);
    wire wr_count = reg_write_in && (reg_addr_in == dspwm_pkg::OFS_COUNT);
    wire wr_flags = reg_write_in && (reg_addr_in == dspwm_pkg::OFS_FLAGS);
    wire wr_dir = reg_write_in && (reg_addr_in == dspwm_pkg::OFS_PIN_DIR);

    // mode decode from both control registers
    wire [2:0] waveform_select = {wave_hi, ctrl_a[dspwm_pkg::WAVE_LO_POS +: 2]}; // RULE19
    wire is_dual = (waveform_select == dspwm_pkg::WAVE_DUAL_MAX)
        || (waveform_select == dspwm_pkg::WAVE_DUAL_CMP); // RULE1
    wire is_fast = (waveform_select == dspwm_pkg::WAVE_FAST_MAX)
        || (waveform_select == dspwm_pkg::WAVE_FAST_CMP);
    wire is_ctc = (waveform_select == dspwm_pkg::WAVE_CTC);
    wire top_from_cmp = (waveform_select == dspwm_pkg::WAVE_DUAL_CMP)
        || (waveform_select == dspwm_pkg::WAVE_FAST_CMP) || is_ctc;
    wire [7:0] top = top_from_cmp ? cmp_act[0] : dspwm_pkg::MAX; // RULE2
    wire dspwm_pkg::dspwm_class_e mode_class = is_dual ? dspwm_pkg::DSPWM_DUAL
        : (is_fast ? dspwm_pkg::DSPWM_FAST : dspwm_pkg::DSPWM_NON_PWM);

    // counter position decode
    wire at_top = (timer_count == top);
    wire at_bottom = (timer_count == dspwm_pkg::BOTTOM);
    // waveform bottom: dual at zero, single at wrap
    wire wave_bottom = is_dual ? at_bottom : at_top;
    // a compare match at zero belongs to the rising slope
    wire match_up = count_up || at_bottom;

    // next count; dual-slope gives 2*top ticks, 510 when top is max
    always_comb begin
        next_count = timer_count;
        next_up = count_up;
        if (is_dual) begin
            if (count_up) begin
                if (timer_count >= top) begin
                    // top held for this one tick, then the slope turns
                    next_up = 1'b0; // RULE3
                    next_count = at_bottom ? timer_count : timer_count - 8'h01; // RULE3 RULE12
                end else begin
                    next_count = timer_count + 8'h01; // RULE1
                end
            end else begin
                if (at_bottom) begin
                    next_up = 1'b1; // RULE1
                    next_count = (top == dspwm_pkg::BOTTOM) ? timer_count : 8'h01;
                end else begin
                    next_count = timer_count - 8'h01; // RULE1
                end
            end
        end else begin
            next_up = 1'b1;
            if ((is_fast || is_ctc) && at_top) begin
                next_count = dspwm_pkg::BOTTOM;
            end else begin
                next_count = timer_count + 8'h01;
            end
        end
    end

    // flag events, valid only on a tick
    wire ovf_event = tick_enable_in && (is_dual
        ? (next_count == dspwm_pkg::BOTTOM && !at_bottom) // RULE4
        : (is_fast ? at_top : timer_count == dspwm_pkg::MAX));
    logic [CHANNELS-1:0] match;
    logic [CHANNELS-1:0] match_event;
    logic [CHANNELS:0] flag_set;
    logic [CHANNELS:0] flag_clr;
    assign flag_set = {match_event, ovf_event};
    assign flag_clr = wr_flags ? reg_wdata_in[CHANNELS:0] : '0;

    // counter and direction; a software write wins over the tick
    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            timer_count <= dspwm_pkg::COUNT_RST;
            count_up <= 1'b1;
        end else if (wr_count) begin
            timer_count <= reg_wdata_in;
            count_up <= count_up || !is_dual;
        end else if (tick_enable_in) begin
            timer_count <= next_count; // RULE13
            count_up <= next_up; // RULE13
        end else if (!is_dual) begin
            count_up <= 1'b1;
        end
    end

    // control, flags, direction; set beats a same-cycle clear
    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            ctrl_a <= dspwm_pkg::CTRL_A_RST;
            wave_hi <= dspwm_pkg::WAVE_HI_RST;
            flags <= '0;
            pin_dir <= '0;
        end else begin
            if (wr_ctrl_a) begin
                ctrl_a <= reg_wdata_in & dspwm_pkg::CTRL_A_WMASK;
            end
            if (wr_ctrl_b) begin
                wave_hi <= reg_wdata_in[dspwm_pkg::WAVE_HI_POS]; // RULE19
            end
            if (wr_dir) begin
                pin_dir <= reg_wdata_in[dspwm_pkg::DIR_POS +: CHANNELS]; // RULE8
            end
            flags <= (flags & ~flag_clr) | flag_set; // RULE4
        end
    end

    // per channel: compare buffer, match and waveform unit
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
            localparam logic [7:0] CH_OFS = dspwm_pkg::OFS_CMP_A + 8'(ch);
            wire wr_cmp = reg_write_in && (reg_addr_in == CH_OFS);
            // pwm modes load the compare at top (dual) or bottom (single)
            wire load_cmp = (mode_class == dspwm_pkg::DSPWM_NON_PWM)
                || (tick_enable_in && at_top);
            wire [1:0] action = (ch == 0)
                ? ctrl_a[dspwm_pkg::ACT_A_POS +: 2]
                : ctrl_a[dspwm_pkg::ACT_B_POS +: 2];

            assign match[ch] = (timer_count == cmp_act[ch]); // RULE20
            assign match_event[ch] = tick_enable_in && match[ch]; // RULE20

            always_ff @(posedge mclk_in) begin
                if (!resetn_in) begin
                    cmp_buf[ch] <= dspwm_pkg::CMP_RST;
                    cmp_act[ch] <= dspwm_pkg::CMP_RST;
                end else begin
                    if (wr_cmp) begin
                        cmp_buf[ch] <= reg_wdata_in;
                    end
                    if (load_cmp) begin
                        cmp_act[ch] <= wr_cmp ? reg_wdata_in : cmp_buf[ch];
                    end
                end
            end

            // only channel a may toggle in the pwm modes
            dspwm_wave_unit #(
                .CAN_TOGGLE(ch == 0)
            ) u_wave (
                .mclk_in(mclk_in),
                .resetn_in(resetn_in),
                .tick_in(tick_enable_in),
                .match_in(match[ch]),
                .cmp_is_top_in(cmp_act[ch] == top),
                .at_top_in(at_top),
                .at_bottom_in(wave_bottom),
                .counting_up_in(match_up),
                .class_in(mode_class),
                .action_in(action),
                .wave_hi_in(wave_hi),
                .port_data_in(port_data_in[ch]),
                .pin_dir_in(pin_dir[ch]),
                .pin_out(pin_out[ch]),
                .pin_oe_out(pin_oe_out[ch]),
                .wave_out(wave_out[ch])
            );
        end
    endgenerate

    // read selection; compare reads give the written value
    wire [7:0] rd_ctrl_b = {4'h0, wave_hi, 3'h0};
    wire [7:0] rd_flags = {{(7 - CHANNELS){1'b0}}, flags};
    wire [7:0] rd_dir = {{(8 - CHANNELS){1'b0}}, pin_dir};
    wire [7:0] rd_value =
        (reg_addr_in == dspwm_pkg::OFS_CTRL_A) ? ctrl_a :
        (reg_addr_in == dspwm_pkg::OFS_CTRL_B) ? rd_ctrl_b :
        (reg_addr_in == dspwm_pkg::OFS_COUNT) ? timer_count :
        (reg_addr_in == dspwm_pkg::OFS_CMP_A) ? cmp_buf[0] :
        (reg_addr_in == dspwm_pkg::OFS_CMP_B) ? cmp_buf[CHANNELS-1] :
        (reg_addr_in == dspwm_pkg::OFS_FLAGS) ? rd_flags :
        (reg_addr_in == dspwm_pkg::OFS_PIN_DIR) ? rd_dir : 8'h00;

    // read data stands one cycle after the strobe
    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            rdata <= 8'h00;
        end else begin
            rdata <= reg_read_in ? rd_value : 8'h00;
        end
    end

    // status outputs
    assign reg_rdata_out = rdata;
    assign timer_count_out = timer_count;
    assign count_up_out = count_up;
    assign overflow_flag_out = flags[dspwm_pkg::FLAG_OVF_POS];
    assign match_flag_out = flags[dspwm_pkg::FLAG_MATCH_POS +: CHANNELS];

endmodule

// ===== dspwm_timer_props.sv
// Purpose: port-level checks of the dual-slope pwm timer
// Assumes: one clock, synchronous active-low reset
// Notes: bound from the bench top file
`timescale 1ns/10ps
module dspwm_timer_props #(
    parameter int unsigned CHANNELS = 2
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic resetn_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    input wire logic [7:0] reg_rdata_out,
    // tick and pins
    input wire logic tick_enable_in,
    input wire logic [CHANNELS-1:0] port_data_in,
    input wire logic [CHANNELS-1:0] pin_out,
    input wire logic [CHANNELS-1:0] pin_oe_out,
    input wire logic [CHANNELS-1:0] wave_out,
    // status
    input wire logic [7:0] timer_count_out,
    input wire logic count_up_out,
    input wire logic overflow_flag_out,
    input wire logic [CHANNELS-1:0] match_flag_out
);
    default clocking dspwm_cb @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);
    // write decodes
    wire dir_wr = reg_write_in && reg_addr_in == dspwm_pkg::OFS_PIN_DIR;
    wire cnt_wr = reg_write_in && reg_addr_in == dspwm_pkg::OFS_COUNT;
    wire ovf_clr = reg_write_in && reg_addr_in == dspwm_pkg::OFS_FLAGS && reg_wdata_in[0];
    a_count_holds: assert property (
        !tick_enable_in && !reg_write_in |=> $stable(timer_count_out))
        else $error("count moved without a tick");
    a_count_step: assert property (
        tick_enable_in && !reg_write_in |=> timer_count_out == $past(timer_count_out) + 8'h01
        || timer_count_out == $past(timer_count_out) - 8'h01 || timer_count_out == 8'h00)
        else $error("count jumped on a tick");
    a_top_once: assert property (
        tick_enable_in && !reg_write_in && timer_count_out == 8'hFF |=> timer_count_out != 8'hFF)
        else $error("max held past one tick");
    a_ovf_bottom: assert property (
        $rose(overflow_flag_out) |-> timer_count_out == 8'h00 && $past(tick_enable_in))
        else $error("overflow set off bottom");
    a_ovf_sticky: assert property (
        overflow_flag_out && !ovf_clr |=> overflow_flag_out)
        else $error("overflow dropped unasked");
    a_wave_on_tick: assert property (
        !tick_enable_in && !reg_write_in |=> $stable(wave_out))
        else $error("wave moved without tick");
    a_oe_dir: assert property (dir_wr |=> pin_oe_out == $past(reg_wdata_in[CHANNELS-1:0]))
        else $error("enable not from direction");
    a_count_load: assert property (cnt_wr |=> timer_count_out == $past(reg_wdata_in))
        else $error("count write not loaded");
    a_read_count: assert property (
        reg_read_in && reg_addr_in == dspwm_pkg::OFS_COUNT |=> reg_rdata_out == $past(timer_count_out))
        else $error("count read wrong");
    a_rdata_idle: assert property (!reg_read_in |=> reg_rdata_out == 8'h00)
        else $error("stray read data");
endmodule

// ===== dspwm_load.sv
// Purpose: load on the waveform pins, resolving the line level
// Assumes: no pull resistor on the lines
// Notes: a released line shows its last driven value inverted
`timescale 1ns/10ps
module dspwm_load (
    // clock
    input wire logic mclk_in,
    // pins from the timer
    input wire logic [1:0] pin_in,
    input wire logic [1:0] oe_in,
    // resolved line level
    output logic [1:0] line_out
);
    logic [1:0] last = 2'h0;
    // remember the driven level so a released line cannot look held
    always @(posedge mclk_in)
        last <= (oe_in & pin_in) | (~oe_in & last);
    // driven line shows the pin
    assign line_out = (oe_in & pin_in) | (~oe_in & ~last);
endmodule

// ===== test_dual_slope_pwm_compare_output.sv
// Purpose: self-checking bench of the dual-slope pwm timer
// Assumes: ticks two cycles apart
// Notes: count and wave model stepped per tick
`timescale 1ns/10ps
module test_dual_slope_pwm_compare_output;
    localparam int unsigned CHANNELS = 2;
    // one run: wave select, compare a/b, action a/b
    typedef struct packed {
        logic [2:0] wsel;
        logic [7:0] cmp_a;
        logic [7:0] cmp_b;
        logic [1:0] act_a;
        logic [1:0] act_b;
    } dspwm_cfg_s;
    localparam dspwm_cfg_s CFGS [10] = '{
        '{3'h1, 8'h02, 8'h80, 2'h2, 2'h3}, '{3'h1, 8'h00, 8'hFF, 2'h2, 2'h2},
        '{3'h1, 8'hFF, 8'h00, 2'h3, 2'h3}, '{3'h5, 8'h10, 8'h05, 2'h2, 2'h1},
        '{3'h5, 8'h10, 8'h05, 2'h1, 2'h3}, '{3'h1, 8'h10, 8'h05, 2'h1, 2'h2},
        '{3'h0, 8'h03, 8'h07, 2'h1, 2'h2}, '{3'h0, 8'h03, 8'h07, 2'h3, 2'h1},
        '{3'h3, 8'h40, 8'hFF, 2'h2, 2'h2}, '{3'h7, 8'h30, 8'h10, 2'h3, 2'h1}};
    logic mclk_in, resetn_in, reg_write_in, reg_read_in, tick_enable_in;
    logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, timer_count_out, d;
    logic [1:0] port_data_in, pin_out, pin_oe_out, wave_out, match_flag_out, line_level;
    logic count_up_out, overflow_flag_out;
    // reference model state
    logic [7:0] m_cnt, m_top;
    logic [7:0] m_cmp [2];
    logic [1:0] m_act [2];
    logic [1:0] m_wave;
    logic m_up, m_hi;
    int m_cls, ovfs, since, errors, samples_checked;
    dspwm_timer #(.CHANNELS(CHANNELS)) dspwm_timer_inst (.mclk_in(mclk_in),
        .resetn_in(resetn_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_write_in(reg_write_in), .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
        .tick_enable_in(tick_enable_in), .port_data_in(port_data_in), .pin_out(pin_out),
        .pin_oe_out(pin_oe_out), .wave_out(wave_out), .timer_count_out(timer_count_out),
        .count_up_out(count_up_out), .overflow_flag_out(overflow_flag_out),
        .match_flag_out(match_flag_out));
    dspwm_load dspwm_load_inst (.mclk_in(mclk_in), .pin_in(pin_out), .oe_in(pin_oe_out),
        .line_out(line_level));
    // free-running clock
    initial begin
        mclk_in = 1'b0;
        forever #2 mclk_in = ~mclk_in;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // one-cycle strobes, result read after the strobe edge
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk_in) {reg_write_in, reg_addr_in, reg_wdata_in} <= {1'b1, a, v};
        @(posedge mclk_in) reg_write_in <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge mclk_in) {reg_read_in, reg_addr_in} <= {1'b1, a};
        @(posedge mclk_in) reg_read_in <= 1'b0;
        #1 v = reg_rdata_out;
    endtask
    // level after a tick taken at count oc
    function automatic logic wave_next(input logic [1:0] act, input logic [7:0] cmp,
        input logic w, input logic [7:0] oc, input logic up, input logic tog);
        logic hit;
        hit = oc == cmp && !(m_cls != 0 && act[1] && cmp == m_top);
        wave_next = w;
        if (act == 2'h1 && (m_cls == 0 || tog) && hit) wave_next = ~w;
        if (act[1] && m_cls != 0 && oc == (m_cls == 1 ? m_top : 8'h00)) wave_next = ~act[0];
        if (act[1] && m_cls == 2 && oc == m_top && cmp == m_top) wave_next = ~act[0];
        if (act[1] && hit) wave_next = (m_cls != 2 || up) ? act[0] : ~act[0];
    endfunction
    // one tick, model step, compare of count, overflow flag, waves and pins
    task automatic do_tick();
        logic [7:0] oc;
        logic conn, tog, exp_pin;
        @(posedge mclk_in) tick_enable_in <= 1'b1;
        @(posedge mclk_in) {tick_enable_in, port_data_in} <= {1'b0, ~port_data_in};
        #1 oc = m_cnt;
        since++;
        if (m_cls != 2) m_cnt = (oc == m_top) ? 8'h00 : oc + 8'h01;
        else if (m_up && oc == m_top) {m_cnt, m_up} = {oc - 8'h01, 1'b0};
        else if (!m_up && oc == 8'h00) {m_cnt, m_up} = {8'h01, 1'b1};
        else m_cnt = m_up ? oc + 8'h01 : oc - 8'h01;
        for (int i = 0; i < 2; i++) begin
            tog = m_hi && i == 0;
            m_wave[i] = wave_next(m_act[i], m_cmp[i], m_wave[i], oc, m_cnt > oc || oc == 8'h00, tog);
            conn = m_act[i] != 2'h0 && !(m_cls != 0 && m_act[i] == 2'h1 && !tog);
            exp_pin = conn ? m_wave[i] : port_data_in[i];
            if (ovfs > 0) check(wave_out[i], m_wave[i]);
            if (ovfs > 0 || !conn) check(pin_out[i], exp_pin);
            if ((ovfs > 0 || !conn) && pin_oe_out[i]) check(line_level[i], exp_pin);
        end
        check(timer_count_out, m_cnt);
        check(overflow_flag_out, m_cnt == 8'h00);
        if (overflow_flag_out === 1'b1) begin
            if (m_cls == 2 && m_top == 8'hFF) check(since, dspwm_pkg::DUAL_PERIOD_TICKS);
            since = 0;
            wr(dspwm_pkg::OFS_FLAGS, 8'h01);
        end
        if (m_cnt == 8'h00) ovfs++;
    endtask
    // set up in normal mode, then tick two periods
    task automatic run_cfg(input dspwm_cfg_s c);
        logic [7:0] ctl;
        ctl = {c.act_a, c.act_b, 2'h0, c.wsel[1:0]};
        wr(dspwm_pkg::OFS_CTRL_A, 8'h00);
        wr(dspwm_pkg::OFS_CMP_A, c.cmp_a);
        wr(dspwm_pkg::OFS_CMP_B, c.cmp_b);
        wr(dspwm_pkg::OFS_CTRL_B, {4'h0, c.wsel[2], 3'h0});
        wr(dspwm_pkg::OFS_CTRL_A, ctl);
        rd(dspwm_pkg::OFS_CTRL_A, d);
        check(d, ctl);
        {m_cmp[0], m_cmp[1], m_act[0], m_act[1], m_hi} = {c.cmp_a, c.cmp_b, c.act_a, c.act_b, c.wsel[2]};
        m_cls = (c.wsel[1:0] == 2'h1) ? 2 : (c.wsel[1:0] == 2'h3) ? 1 : 0;
        m_top = (m_cls != 0 && c.wsel[2]) ? c.cmp_a : 8'hFF;
        {ovfs, since} = {32'd0, 32'd0};
        for (int k = 0; k < 1100 && ovfs < 2; k++)
            do_tick();
        check(ovfs, 2);
    endtask
    // reset, register checks, then each run
    initial begin
        {resetn_in, reg_write_in, reg_read_in, tick_enable_in} = 4'h0;
        {reg_addr_in, reg_wdata_in, port_data_in} = 18'h0;
        {m_cnt, m_wave, m_up} = {8'h00, 2'h0, 1'b1};
        {errors, samples_checked} = {32'd0, 32'd0};
        repeat (8) @(posedge mclk_in);
        resetn_in <= 1'b1;
        rd(dspwm_pkg::OFS_CTRL_A, d);
        check(d, dspwm_pkg::CTRL_A_RST);
        check(pin_oe_out, dspwm_pkg::PIN_DIR_RST);
        check(pin_out, port_data_in);
        wr(dspwm_pkg::OFS_CTRL_A, 8'hFF);
        rd(dspwm_pkg::OFS_CTRL_A, d);
        check(d, dspwm_pkg::CTRL_A_WMASK);
        rd(8'h50, d);
        check(d, 8'h00);
        wr(dspwm_pkg::OFS_COUNT, 8'h55);
        rd(dspwm_pkg::OFS_COUNT, d);
        check(d, 8'h55);
        wr(dspwm_pkg::OFS_COUNT, 8'h00);
        wr(dspwm_pkg::OFS_PIN_DIR, 8'h01);
        check(pin_oe_out, 2'h1);
        wr(dspwm_pkg::OFS_PIN_DIR, 8'h03);
        for (int n = 0; n < 10; n++)
            run_cfg(CFGS[n]);
        tally_and_finish();
    end
    // watchdog, over twice the run length
    initial begin
        #200000;
        errors++;
        tally_and_finish();
    end
endmodule
bind dspwm_timer dspwm_timer_props #(.CHANNELS(CHANNELS)) dspwm_timer_props_inst (
    .mclk_in(mclk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
    .reg_rdata_out(reg_rdata_out), .tick_enable_in(tick_enable_in),
    .port_data_in(port_data_in), .pin_out(pin_out), .pin_oe_out(pin_oe_out),
    .wave_out(wave_out), .timer_count_out(timer_count_out), .count_up_out(count_up_out),
    .overflow_flag_out(overflow_flag_out), .match_flag_out(match_flag_out));
